// ==== osg_clock_unit.sv ====
// clock generation and supervision: source selection, dividers, option load
// assumes option straps are stable at reset release; one 50 MHz core clock
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module ocu_clock_unit
  import ocu_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // option straps
  input wire logic guard_enable_option_i,
  input wire logic osc_type_option_i,
  // main oscillator input and oscillator enables
  input wire logic main_osc_i,
  output logic main_osc_en_o,
  output logic aux_osc_en_o,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // derived clocks
  output logic int_clk_tick_o,
  output logic periph_tick_o,
  output logic core_tick_o,
  // instruction timing
  input wire logic instr_start_i,
  input wire logic [1:0] instr_len_i,
  output logic instr_busy_o,
  output logic instr_done_o,
  // status
  output logic clk_src_aux_o,
  output logic por_done_o,
  output logic rc_mode_o,
  output logic guard_active_o
);

  localparam int AUX_WAIT_MAX = AUX_DIV_CYC + 1;

  ocu_state_t state_ff;
  ocu_state_t nxt_state;
  logic opt_ld_ff;
  logic guard_opt_ff;
  logic rc_opt_ff;
  logic main_osc_stop_ff;
  logic [6:0] aux_cnt_ff;
  logic [6:0] por_cnt_ff;
  logic [4:0] start_cnt_ff;
  logic [5:0] tail_cnt_ff;
  logic [7:0] rdata_ff;
  logic [2:0] mc_cnt_ff;
  logic [2:0] mc_target_ff;
  logic instr_busy_ff;
  logic instr_done_ff;
  logic main_edge;
  logic main_miss;
  logic aux_en;
  logic aux_tick;
  logic int_tick;
  logic por_tick;
  logic por_done;
  logic start_done;
  logic tail_done;
  logic ccr_wr;
  logic [7:0] ccr_rd;
  logic [7:0] stat_rd;
  logic [7:0] nxt_rdata;
  logic [2:0] mc_len;
  logic mc_last;

  ocu_tick_if periph_if ();
  ocu_tick_if core_if ();

  ////////////////////////////////////////////////////////////////////////////
  // option load after reset release
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      opt_ld_ff <= 1'b0;
      guard_opt_ff <= 1'b0;
      rc_opt_ff <= 1'b0;
    end
    else if (!opt_ld_ff)
    begin
      opt_ld_ff <= 1'b1;
      guard_opt_ff <= guard_enable_option_i; // [R17] [R13]
      rc_opt_ff <= osc_type_option_i; // [R18] [R4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main oscillator edge qualification
  ocu_guard_filter u_filter (
    .core_clk_i (core_clk_i),
    .rst_n_i (rst_n_i),
    .osc_i (main_osc_i && main_osc_en_o),
    .guard_en_i (guard_opt_ff),
    .edge_o (main_edge),
    .miss_o (main_miss)
  );

  ////////////////////////////////////////////////////////////////////////////
  // auxiliary oscillator, phase restarts whenever it is enabled
  assign aux_en = guard_opt_ff && (state_ff != ST_MAIN); // [R12] [R13]
  assign aux_tick = aux_en && (aux_cnt_ff == 7'(AUX_DIV_CYC - 1));

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      aux_cnt_ff <= 7'h0;
    else if (!aux_en || aux_tick)
      aux_cnt_ff <= 7'h0; // [R20]
    else
      aux_cnt_ff <= aux_cnt_ff + 7'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-on delay counter
  assign por_tick = guard_opt_ff ? aux_tick : main_edge; // [R11]
  assign por_done = por_cnt_ff == POR_TICKS;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      por_cnt_ff <= 7'h0;
    else if (state_ff == ST_POR && por_tick && !por_done)
      por_cnt_ff <= por_cnt_ff + 7'h1; // [R11]
  end

  ////////////////////////////////////////////////////////////////////////////
  // start-up edge count and auxiliary-rate instruction tail
  assign start_done = start_cnt_ff == STARTUP_EDGES;
  assign tail_done = tail_cnt_ff == CLR_AUX_TICKS - 6'h1;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      start_cnt_ff <= 5'h0;
    else if (!main_osc_en_o || main_miss || state_ff == ST_MAIN)
      start_cnt_ff <= 5'h0;
    else if (main_edge && !start_done)
      start_cnt_ff <= start_cnt_ff + 5'h1;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tail_cnt_ff <= 6'h0;
    else if (state_ff != ST_RESTART || !start_done)
      tail_cnt_ff <= 6'h0;
    else if (aux_tick && !tail_done)
      tail_cnt_ff <= tail_cnt_ff + 6'h1; // [R8]
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_POR:
        if (opt_ld_ff && por_done && (start_done || !guard_opt_ff))
          nxt_state = ST_MAIN; // [R11]
      ST_MAIN:
        if (guard_opt_ff && main_osc_stop_ff)
          nxt_state = ST_AUX; // [R5] [R6] [R19]
        else if (guard_opt_ff && main_miss)
          nxt_state = ST_AUX_WAIT; // [R9]
      ST_AUX_WAIT:
        if (aux_tick)
          nxt_state = ST_AUX; // [R9]
      ST_AUX:
        if (!main_osc_stop_ff)
          nxt_state = ST_RESTART; // [R7]
      ST_RESTART:
        if (main_osc_stop_ff)
          nxt_state = ST_AUX;
        else if (start_done && tail_done && aux_tick)
          nxt_state = ST_MAIN; // [R8]
      default:
        nxt_state = ST_POR;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_ff <= ST_POR; // [R7]
    else
      state_ff <= nxt_state;
  end

  // internal clock: one source at a time; switch back to main only on an auxiliary tick
  assign int_tick = (state_ff == ST_MAIN) ? main_edge :
                    ((state_ff == ST_AUX || state_ff == ST_RESTART) ? aux_tick : 1'b0); // [R20]
  assign main_osc_en_o = !(guard_opt_ff && main_osc_stop_ff); // [R5] [R19]
  assign aux_osc_en_o = aux_en;
  assign int_clk_tick_o = int_tick;
  assign clk_src_aux_o = state_ff == ST_AUX || state_ff == ST_RESTART; // [R6] [R10]
  assign por_done_o = state_ff != ST_POR;
  assign rc_mode_o = rc_opt_ff; // [R18]
  assign guard_active_o = guard_opt_ff;

  ////////////////////////////////////////////////////////////////////////////
  // dividers
  ocu_div #(.DIV(PERIPH_DIV)) u_periph_div (
    .core_clk_i (core_clk_i),
    .rst_n_i (rst_n_i),
    .tick_i (int_tick),
    .out_if (periph_if)
  );

  ocu_div #(.DIV(CORE_DIV)) u_core_div (
    .core_clk_i (core_clk_i),
    .rst_n_i (rst_n_i),
    .tick_i (int_tick),
    .out_if (core_if)
  );

  assign periph_tick_o = periph_if.tick; // [R1]
  assign core_tick_o = core_if.tick; // [R2] [R10]

  ////////////////////////////////////////////////////////////////////////////
  // register port
  assign ccr_wr = wr_i && (addr_i == CCR_ADDR);
  assign ccr_rd = {5'h00, main_osc_stop_ff, 2'h0}; // [R16]
  assign stat_rd = {4'h0, rc_opt_ff, guard_opt_ff, state_ff == ST_MAIN, clk_src_aux_o};
  assign nxt_rdata = !rd_i ? 8'h00 :
                     (addr_i == CCR_ADDR) ? ccr_rd :
                     (addr_i == STAT_ADDR) ? stat_rd : 8'h00;
  assign rdata_o = rdata_ff;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      main_osc_stop_ff <= CCR_STOP_RST; // [R7]
    else if (ccr_wr)
      main_osc_stop_ff <= wdata_i[CCR_STOP_BIT]; // [R5]
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction machine-cycle timing
  assign mc_len = (instr_len_i == INSTR_LEN_2) ? MC_2 :
                  ((instr_len_i == INSTR_LEN_4) ? MC_4 : MC_5); // [R3]
  assign mc_last = core_if.tick && (mc_cnt_ff == mc_target_ff - 3'h1);
  assign instr_busy_o = instr_busy_ff;
  assign instr_done_o = instr_done_ff;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mc_cnt_ff <= 3'h0;
      mc_target_ff <= MC_2;
      instr_busy_ff <= 1'b0;
      instr_done_ff <= 1'b0;
    end
    else
    begin
      instr_done_ff <= instr_busy_ff && mc_last; // [R3]
      if (!instr_busy_ff && instr_start_i)
      begin
        mc_cnt_ff <= 3'h0;
        mc_target_ff <= mc_len;
        instr_busy_ff <= 1'b1;
      end
      else if (instr_busy_ff && core_if.tick)
      begin
        mc_cnt_ff <= mc_cnt_ff + 3'h1;
        instr_busy_ff <= !mc_last;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_stop_request;
    state_ff == ST_MAIN && guard_opt_ff && main_osc_stop_ff;
  endsequence

  sequence s_on_aux;
    state_ff == ST_AUX && !main_osc_en_o && aux_osc_en_o;
  endsequence

  a_stop_to_aux: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R5]
    s_stop_request |=> s_on_aux)
    else $error("stop bit did not hand the clock to the auxiliary oscillator");

  a_aux_drives_clk: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R6]
    state_ff == ST_AUX |-> int_tick == aux_tick)
    else $error("internal clock not taken from auxiliary oscillator");

  a_no_guard_main: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R19]
    opt_ld_ff && !guard_opt_ff |-> main_osc_en_o && !clk_src_aux_o)
    else $error("main oscillator stopped without guard");

  a_aux_gated: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R13]
    opt_ld_ff && !guard_opt_ff |-> !aux_osc_en_o)
    else $error("auxiliary oscillator used with guard off");

  a_aux_off_main: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R12]
    state_ff == ST_MAIN |-> !aux_osc_en_o)
    else $error("auxiliary oscillator running beside main");

  a_miss_switch: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R9]
    $rose(state_ff == ST_AUX_WAIT) |->
      !int_tick throughout (##[1:AUX_WAIT_MAX] state_ff == ST_AUX))
    else $error("auxiliary clock not started one period after missing edge");

  a_restart_delay: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R8]
    state_ff == ST_RESTART ##1 state_ff == ST_MAIN |->
      $past(start_done) && $past(tail_cnt_ff) == CLR_AUX_TICKS - 6'h1)
    else $error("main oscillator took over before restart delay");

  a_instr_len: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R3]
    instr_done_o |-> $past(mc_cnt_ff) == mc_target_ff - 3'h1 && $past(core_if.tick))
    else $error("instruction length in machine cycles wrong");

endmodule

// ==== osg_pkg.sv ====
// constants, states and register map of the oscillator safeguard clock unit
// assumes a single 50 MHz core clock; oscillator edges arrive as sampled levels
// Functional notes
// [R1] timer, converter, watchdog clock is internal divided by 12
// [R2] core machine cycle is internal clock divided by 13
// [R3] instructions last two, four or five machine cycles
// [R4] oscillator source fixed by configuration option
// [R5] stop bit high stops main oscillator when guarded
// [R6] software stop starts auxiliary oscillator as clock
// [R7] clearing stop bit or any reset restarts main
// [R8] restart waits start-up plus one auxiliary-rate instruction
// [R9] auxiliary clock begins one period after missing edge
// [R10] code runs normally at reduced auxiliary rate
// [R11] auxiliary oscillator clocks power-on delay counter; with the guard option off the code counts main oscillator edges instead
// [R12] auxiliary oscillator off once main oscillator runs
// [R13] guard set only by option; gates auxiliary use
// [R14] guard drops spike edges, caps internal frequency
// [R15] avoid guard for precise timing or serial links
// [R16] other converter control bits have no function
// [R17] guard enable option loaded at reset
// [R18] oscillator type option selects resistor network mode
// [R19] without guard, stop bit cannot stop main oscillator
// [R20] source switching glitch-free, no short clock pulse
package ocu_pkg;

  // timing base
  localparam int CLK_PERIOD_NS = 20;
  localparam int AUX_PERIOD_NS = 2000;
  localparam int AUX_DIV_CYC = AUX_PERIOD_NS / CLK_PERIOD_NS;
  localparam int GUARD_MIN_NS = 125;
  localparam int GUARD_MIN_CYC = (GUARD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MISS_NS = 1000;
  localparam int MISS_CYC = MISS_NS / CLK_PERIOD_NS;

  // divider ratios
  localparam int PERIPH_DIV = 12;
  localparam int CORE_DIV = 13;

  // start-up and power-on counts
  localparam logic [4:0] STARTUP_EDGES = 5'h10;
  localparam int CLR_INSTR_MC = 4;
  localparam logic [5:0] CLR_AUX_TICKS = 6'(CLR_INSTR_MC * CORE_DIV);
  localparam logic [6:0] POR_TICKS = 7'h40;

  // register map
  localparam logic [7:0] CCR_ADDR = 8'hD1;
  localparam logic [7:0] STAT_ADDR = 8'hD3;
  localparam int CCR_STOP_BIT = 2;
  localparam logic CCR_STOP_RST = 1'b0;
  localparam int STAT_AUX_BIT = 0;
  localparam int STAT_MAIN_BIT = 1;
  localparam int STAT_GUARD_BIT = 2;
  localparam int STAT_RC_BIT = 3;

  // instruction lengths in machine cycles
  localparam logic [1:0] INSTR_LEN_2 = 2'h0;
  localparam logic [1:0] INSTR_LEN_4 = 2'h1;
  localparam logic [2:0] MC_2 = 3'h2;
  localparam logic [2:0] MC_4 = 3'h4;
  localparam logic [2:0] MC_5 = 3'h5;

  typedef enum logic [2:0] {
    ST_POR,
    ST_MAIN,
    ST_AUX_WAIT,
    ST_AUX,
    ST_RESTART
  } ocu_state_t;

endpackage

// ==== osg_tick_if.sv ====
// one-cycle tick carrier between the clock unit and its dividers
// assumes producer and consumer share the core clock
`timescale 1ns/1ps
interface ocu_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface

// ==== osg_div.sv ====
// tick divider: one output tick per DIV input ticks
// assumes input ticks are single-cycle pulses on the core clock
`timescale 1ns/1ps
module ocu_div
  import ocu_pkg::*;
#(
  parameter int DIV = 12
)
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // ticks
  input wire logic tick_i,
  ocu_tick_if.src out_if
);

  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic tick_ff;
  logic wrap;
  logic [3:0] seen_ff;

  assign wrap = tick_i && (cnt_ff == 4'(DIV - 1));
  assign nxt_cnt = wrap ? 4'h0 : (tick_i ? cnt_ff + 4'h1 : cnt_ff);
  assign out_if.tick = tick_ff;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_ff <= 4'h0;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tick_ff <= wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input ticks counted between output ticks
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      seen_ff <= 4'h0;
    else if (tick_ff)
      seen_ff <= tick_i ? 4'h1 : 4'h0;
    else
      seen_ff <= seen_ff + (tick_i ? 4'h1 : 4'h0);
  end

  a_div_ratio: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R1] [R2]
    tick_ff |-> seen_ff == 4'(DIV))
    else $error("divider output tick not after DIV input ticks");

endmodule

// ==== osg_guard_filter.sv ====
// main oscillator edge qualifier: spike rejection and missing-edge detection
// assumes the oscillator level is sampled synchronously to the core clock
`timescale 1ns/1ps
module ocu_guard_filter
  import ocu_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // oscillator and control
  input wire logic osc_i,
  input wire logic guard_en_i,
  // qualified outputs
  output logic edge_o,
  output logic miss_o
);

  logic osc_d_ff;
  logic [5:0] gap_ff;
  logic [5:0] nxt_gap;
  logic edge_ff;
  logic rise;
  logic spaced;
  logic accept;

  assign rise = osc_i && !osc_d_ff;
  assign spaced = gap_ff >= 6'(GUARD_MIN_CYC - 1);
  assign accept = rise && (!guard_en_i || spaced); // [R14]
  assign nxt_gap = accept ? 6'h0 : (gap_ff == 6'(MISS_CYC) ? gap_ff : gap_ff + 6'h1);
  assign edge_o = edge_ff;
  assign miss_o = gap_ff == 6'(MISS_CYC);

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      osc_d_ff <= 1'b0;
      gap_ff <= 6'h0;
      edge_ff <= 1'b0;
    end
    else
    begin
      osc_d_ff <= osc_i;
      gap_ff <= nxt_gap;
      edge_ff <= accept;
    end
  end

  a_edge_spacing: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R14]
    edge_o && guard_en_i |=> !edge_o [*5])
    else $error("accepted edges closer than the guard minimum");

endmodule

// ==== tb_top.sv ====
// self-checking bench for the oscillator safeguard clock unit
// assumes the unit's own assertions sit in its files; bench models the oscillator pin
`timescale 1ns/1ps
module tb_top
  import ocu_pkg::*;
;
  logic core_clk_i, rst_n_i, guard_enable_option_i, osc_type_option_i, main_osc_i;
  logic main_osc_en_o, aux_osc_en_o, wr_i, rd_i, int_clk_tick_o, periph_tick_o, core_tick_o;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic instr_start_i, instr_busy_o, instr_done_o;
  logic [1:0] instr_len_i;
  logic clk_src_aux_o, por_done_o, rc_mode_o, guard_active_o;
  logic osc_run;
  int osc_half, osc_cnt, n_mismatch, total_checks, cyc;

  ocu_clock_unit dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .guard_enable_option_i(guard_enable_option_i), .osc_type_option_i(osc_type_option_i),
    .main_osc_i(main_osc_i), .main_osc_en_o(main_osc_en_o), .aux_osc_en_o(aux_osc_en_o),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .int_clk_tick_o(int_clk_tick_o), .periph_tick_o(periph_tick_o), .core_tick_o(core_tick_o),
    .instr_start_i(instr_start_i), .instr_len_i(instr_len_i), .instr_busy_o(instr_busy_o),
    .instr_done_o(instr_done_o), .clk_src_aux_o(clk_src_aux_o), .por_done_o(por_done_o),
    .rc_mode_o(rc_mode_o), .guard_active_o(guard_active_o));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk_i = 1'b0;
    forever #(CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;
  end

  // main oscillator stands still while disabled or stopped
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (osc_run && main_osc_en_o)
    begin
      if (osc_cnt >= osc_half - 1)
      begin
        osc_cnt <= 0;
        main_osc_i <= ~main_osc_i;
      end
      else
        osc_cnt <= osc_cnt + 1;
    end
    if (cyc == 40000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, exp, rdata_o);
    tick();
    chk("rdata_idle", 8'h00, rdata_o);
  endtask

  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic do_reset(input logic guard, input logic rc, output int por_cyc);
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    guard_enable_option_i <= guard;
    osc_type_option_i <= rc;
    repeat (10) tick();
    chk("rst_main_en", 1'b1, main_osc_en_o);
    chk("rst_aux_en", 1'b0, aux_osc_en_o);
    chk("rst_por", 1'b0, por_done_o);
    @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    por_cyc = 0;
    while (por_done_o !== 1'b1 && por_cyc < 9000)
    begin
      tick();
      por_cyc++;
    end
    repeat (400) tick();
    chk("aux_off", 1'b0, aux_osc_en_o);
    chk("src_main", 1'b0, clk_src_aux_o);
    chk("guard_latch", guard, guard_active_o);
    chk("rc_latch", rc, rc_mode_o);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_unguarded();
    int p;
    do_reset(1'b0, 1'b1, p);
    chk("por_main_edges", 1'b1, p < 1000);
    rd_chk("status", STAT_ADDR, 8'h0A);
    wr(CCR_ADDR, 8'hFB);
    rd_chk("ccr_unused", CCR_ADDR, 8'h00);
    rd_chk("unmapped", 8'h55, 8'h00);
    wr(CCR_ADDR, 8'hFF);
    rd_chk("ccr_stop", CCR_ADDR, 8'h04);
    repeat (300) tick();
    chk("no_stop", 1'b1, main_osc_en_o);
    chk("no_aux", 1'b0, clk_src_aux_o | aux_osc_en_o);
    $display("test unguarded done");
  endtask

  task automatic t_dividers();
    int i, n, k;
    for (i = 0; i < 2; i++)
    begin
      k = 0;
      while ((i ? core_tick_o : periph_tick_o) !== 1'b1 && k < 400)
      begin
        tick();
        k++;
      end
      n = 0;
      do
      begin
        n += (int_clk_tick_o === 1'b1);
        tick();
        k++;
      end
      while ((i ? core_tick_o : periph_tick_o) !== 1'b1 && k < 800);
      chk(i ? "core_div" : "periph_div", i ? 16'(CORE_DIV) : 16'(PERIPH_DIV), 16'(n));
    end
    $display("test dividers done");
  endtask

  task automatic t_instr();
    int len, n, k;
    for (len = 0; len < 4; len++)
    begin
      @(posedge core_clk_i);
      instr_start_i <= 1'b1;
      instr_len_i <= 2'(len);
      @(posedge core_clk_i);
      instr_start_i <= 1'b0;
      #1;
      chk("busy", 1'b1, instr_busy_o);
      n = 0;
      k = 0;
      while (instr_done_o !== 1'b1 && k < 2000)
      begin
        n += (core_tick_o === 1'b1);
        tick();
        k++;
      end
      chk("mc_count", len == 0 ? 16'h2 : (len == 1 ? 16'h4 : 16'h5), 16'(n));
    end
    $display("test instruction timing done");
  endtask

  task automatic t_stop_restart();
    int k;
    rd_chk("stop_cleared", CCR_ADDR, 8'h00);
    wr(CCR_ADDR, 8'h04);
    tick();
    chk("main_off", 1'b0, main_osc_en_o);
    repeat (3) tick();
    chk("aux_on", 1'b1, aux_osc_en_o);
    chk("src_aux", 1'b1, clk_src_aux_o);
    rd_chk("status_aux", STAT_ADDR, 8'h05);
    wr(CCR_ADDR, 8'h00);
    tick();
    chk("main_on", 1'b1, main_osc_en_o);
    k = 0;
    while (clk_src_aux_o !== 1'b0 && k < 8000)
    begin
      tick();
      k++;
    end
    chk("restart_delay", 1'b1, k >= 5100 && k <= 5600);
    chk("aux_stopped", 1'b0, aux_osc_en_o);
    $display("test stop and restart done");
  endtask

  task automatic t_missing();
    int k;
    osc_run <= 1'b0;
    k = 0;
    while (clk_src_aux_o !== 1'b1 && k < 400)
    begin
      tick();
      k++;
    end
    chk("miss_switch", 1'b1, k >= 135 && k <= 175);
    chk("miss_aux_en", 1'b1, aux_osc_en_o);
    osc_run <= 1'b1;
    k = 0;
    while (clk_src_aux_o !== 1'b0 && k < 8000)
    begin
      tick();
      k++;
    end
    chk("miss_back", 1'b0, clk_src_aux_o);
    $display("test missing edge done");
  endtask

  task automatic t_spikes();
    int k, last, gap, n;
    osc_half <= 1;
    gap = 1000;
    last = 0;
    n = 0;
    for (k = 0; k < 300; k++)
    begin
      tick();
      if (int_clk_tick_o === 1'b1)
      begin
        if (n > 0 && k - last < gap)
          gap = k - last;
        last = k;
        n++;
      end
    end
    chk("spike_ticks", 1'b1, n > 20);
    chk("spike_gap", 1'b1, gap >= GUARD_MIN_CYC);
    osc_half <= 5;
    repeat (100) tick();
    $display("test spike filter done");
  endtask

  // guard on: no serial links and no precise timing in this bench
  task automatic t_guarded_por();
    int p;
    do_reset(1'b1, 1'b0, p);
    chk("por_aux_ticks", 1'b1, p >= 6300 && p <= 6500);
    $display("test guarded power-on done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    rst_n_i = 1'b0;
    guard_enable_option_i = 1'b0;
    osc_type_option_i = 1'b0;
    main_osc_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    instr_start_i = 1'b0;
    instr_len_i = 2'h0;
    osc_run = 1'b1;
    osc_half = 5;
    osc_cnt = 0;
    n_mismatch = 0;
    total_checks = 0;
    cyc = 0;
    t_unguarded();
    t_dividers();
    t_guarded_por();
    t_instr();
    t_stop_restart();
    t_missing();
    t_spikes();
    report_and_stop();
  end
endmodule
